// ==== bench/gpio_pad_model.sv ====
`timescale 1ns/1ps
// -----------------------------------------------
// Pad ring model: resolves each port A pin level.
// -----------------------------------------------
module gpio_pad_model (
  input wire logic clk_i,
  input wire logic [15:0] out_i,
  input wire logic [15:0] oe_i,
  input wire logic [15:0] pu_i,
  input wire logic [15:0] pd_i,
  output logic [15:0] level_o
);
  // A floating pin never holds a steady level, so it toggles each cycle.
  logic [15:0] float_ff = 16'hA5C3;
  always @(posedge clk_i) begin
    float_ff <= ~float_ff;
  end
  // pull-up first
  // Released pins take the pull-up, then the pull-down, else they float.
  always_comb begin
    level_o = (oe_i & out_i) | (~oe_i & pu_i) |
              (~oe_i & ~pu_i & ~pd_i & float_ff);
  end
endmodule : gpio_pad_model

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`include "gpio_pin_regs.svh"
module testbench;
  // ---------------------------------------------
  // Stimulus, outputs and the reference model.
  // ---------------------------------------------
  logic clk_i = 0, rst_i = 1, read_i = 0, write_i = 0, ce_i = 1;
  logic pa_port_rst_i = 0, pb_port_rst_i = 0;
  logic [13:0] address_i = 14'h0000;
  logic [31:0] writedata_i = 32'h0;
  logic [3:0] byteenable_i = 4'hF;
  logic [31:0] readdata_o, pad_drv, rd;
  logic [1:0] response_o, rsp;
  logic waitrequest_o, locked_o;
  logic [15:0] pad_in, pad_out, pad_oe, pad_ien, pad_pu, pad_pd, pb_oe, lock_o;
  int failures = 0, checks = 0, seed = 4497, i, v;
  // Model state of every register except the input register, kept as plain integers.
  int dir, inen, pu, pd, od, drv, dout, pb, lk, locked;
  int regs[9] = '{'h00, 'h04, 'h08, 'h0C, 'h10, 'h14, 'h20, 'h24, 'h2000};
  localparam int PM = `GP_PA_PIN_MASK;
  // 100 ns period.
  always #50 clk_i = ~clk_i;
  gpio_port_pin_control dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .response_o(response_o), .pa_port_rst_i(pa_port_rst_i),
    .pb_port_rst_i(pb_port_rst_i), .pa_pad_in_i(pad_in),
    .pa_pad_out_o(pad_out), .pa_pad_oe_o(pad_oe), .pa_pad_ien_o(pad_ien),
    .pa_pad_pullup_o(pad_pu), .pa_pad_pulldown_o(pad_pd),
    .pa_pad_drive_o(pad_drv), .pa_pin_lock_o(lock_o),
    .pa_locked_o(locked_o), .pb_pad_oe_o(pb_oe));
  gpio_pad_model pads (.clk_i(clk_i), .out_i(pad_out), .oe_i(pad_oe),
    .pu_i(pad_pu), .pd_i(pad_pd), .level_o(pad_in));
  // ---------------------------------------------
  // Model functions.
  // ---------------------------------------------
  // Locked pins keep their old bits; reserved bits always read zero.
  function automatic int mix(int o, int d, int k);
    return (o & k) | (d & ~k & PM);
  endfunction : mix
  // Widens per-pin lock bits to the two-bit drive fields.
  function automatic int dk(int k);
    int r;
    r = 0;
    for (int j = 0; j < 16; j++) if (k[j]) r |= 3 << (2 * j);
    return r;
  endfunction : dk
  function automatic void mw(int a, int d);
    int k;
    k = locked ? lk : 0;
    case (a)
      'h00: dir = mix(dir, d, k);
      'h04: inen = mix(inen, d, k);
      'h08: pu = mix(pu, d, k);
      'h0C: pd = mix(pd, d, k);
      'h10: od = mix(od, d, k);
      'h14: drv = (drv & dk(k)) | (d & ~dk(k) & `GP_PA_DRV_MASK);
      'h18: begin
        // Only one keyed write with both upper lanes enabled counts.
        if (!locked && d[31:16] == `GP_LOCK_KEY &&
            byteenable_i[3:2] == 2'b11) begin
          locked = 1;
          lk = d & PM;
        end
      end
      'h20: dout = d & PM;
      // Set is applied after clear, so set wins on a shared pin.
      'h24: dout = ((dout & ~(d >> 16)) | d) & PM;
      'h28: dout = dout & ~d;
      'h2000: pb = d & `GP_PB_PIN_MASK;
      default: ;
    endcase
  endfunction : mw
  function automatic int mr(int a);
    case (a)
      'h00: return dir;
      'h04: return inen;
      'h08: return pu;
      'h0C: return pd;
      'h10: return od;
      'h14: return drv;
      'h18: return (locked << 16) | lk;
      'h20: return dout;
      'h2000: return pb;
      default: return 0;
    endcase
  endfunction : mr
  function automatic void mreset();
    dir = 0; inen = 'h0200; pu = 'h3200; pd = 0; od = 0;
    drv = 0; dout = 0; lk = 0; locked = 0;
  endfunction : mreset
  // ---------------------------------------------
  // Bus and check tasks.
  // ---------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  // Holds the request until waitrequest is sampled low at a rising edge,
  // takes the answer at that same edge and only then releases it.
  task automatic bus(input logic w, input logic [13:0] a,
                     input logic [31:0] d);
    bit ok;
    ok = 0;
    @(posedge clk_i);
    read_i <= !w; write_i <= w; address_i <= a; writedata_i <= d;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge clk_i);
      if (waitrequest_o === 1'b0) begin
        ok = 1; rd = readdata_o; rsp = response_o;
      end
    end
    read_i <= 1'b0; write_i <= 1'b0;
    if (!ok) begin
      failures++;
      print_verdict();
    end
    if (w) mw(a, d);
  endtask : bus
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    chk(32'(rsp), `GP_RESP_OKAY);
  endtask : wr
  task automatic rdc(input logic [13:0] a);
    bus(1'b0, a, 32'h0);
    chk(rd, mr(a));
  endtask : rdc
  // Pad copies follow one edge after the register lands.
  task automatic padchk();
    repeat (2) @(negedge clk_i);
    chk(32'(pad_pd), pd & ~pu);
    chk(32'(pad_pu), pu);
    chk(pad_drv, drv);
    chk(32'(pad_oe), dir & ~(od & dout));
    chk(32'(pad_out), dout & ~od);
    chk(32'(pad_ien), inen);
    chk(32'(pb_oe), pb);
    chk(32'(lock_o), lk);
    chk(32'(locked_o), locked);
  endtask : padchk
  // ---------------------------------------------
  // Main sequence.
  // ---------------------------------------------
  initial begin
    mreset();
    pb = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 9; i++) rdc(regs[i]);
    rdc('h28);
    padchk();
    $display("reset values done");
    repeat (4) for (i = 0; i < 9; i++) begin
      wr(regs[i], $random(seed));
      rdc(regs[i]);
    end
    padchk();
    wr('h20, 0);
    wr('h24, 32'hFFFFFFFF);
    rdc('h20);
    wr('h24, 32'hFFFF0000);
    rdc('h20);
    wr('h24, 32'h00F00F00);
    wr('h28, 32'hFFFF0F0F);
    rdc('h20);
    rdc('h24);
    $display("set clear done");
    wr('h00, 32'hFFFF);
    wr('h10, 0);
    repeat (4) begin
      wr('h04, $random(seed));
      wr('h20, $random(seed));
      wr('h1C, 32'hFFFFFFFF);
      repeat (3) @(negedge clk_i);
      bus(1'b0, 'h1C, 0);
      chk(rd, dout & inen);
    end
    wr('h00, 0);
    wr('h0C, PM);
    wr('h08, PM);
    wr('h04, PM);
    repeat (3) @(negedge clk_i);
    bus(1'b0, 'h1C, 0);
    chk(rd, PM);
    bus(1'b0, 'h0300, 0);
    chk(32'(rsp), `GP_RESP_SLVERR);
    chk(rd, 0);
    bus(1'b1, 'h0302, 32'hFFFF);
    chk(32'(rsp), `GP_RESP_SLVERR);
    $display("input and map done");
    v = $random(seed);
    wr('h18, {16'h5FA1, v[15:0]});
    rdc('h18);
    byteenable_i <= 4'h3;
    wr('h18, {`GP_LOCK_KEY, v[15:0]});
    byteenable_i <= 4'hF;
    rdc('h18);
    wr('h18, {`GP_LOCK_KEY, v[15:0]});
    rdc('h18);
    wr('h18, {`GP_LOCK_KEY, 16'hFFFF});
    rdc('h18);
    repeat (2) for (i = 0; i < 9; i++) begin
      wr(regs[i], $random(seed));
      rdc(regs[i]);
    end
    padchk();
    $display("lock done");
    // A port reset while the clock enable is low must change nothing.
    @(posedge clk_i);
    ce_i <= 1'b0;
    pa_port_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
    pa_port_rst_i <= 1'b0;
    rdc('h18);
    for (i = 0; i < 9; i++) rdc(regs[i]);
    padchk();
    $display("clock enable done");
    @(posedge clk_i);
    pa_port_rst_i <= 1'b1;
    pb_port_rst_i <= 1'b1;
    @(posedge clk_i);
    pa_port_rst_i <= 1'b0;
    pb_port_rst_i <= 1'b0;
    mreset();
    pb = 0;
    rdc('h18);
    for (i = 0; i < 9; i++) rdc(regs[i]);
    padchk();
    wr('h18, {`GP_LOCK_KEY, 16'h0201});
    rdc('h18);
    $display("port reset done");
    print_verdict();
  end
endmodule : testbench

// ==== core/gpio_pin_pkg.sv ====
package gpio_pin_pkg;

  // Bus answer sequencer: idle, or presenting the answer for one cycle.
  typedef enum logic {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;

  // One register word.
  typedef logic [31:0] word_t;

endpackage : gpio_pin_pkg

// ==== core/gpio_pin_regs.svh ====
`ifndef GPIO_PIN_REGS_SVH
`define GPIO_PIN_REGS_SVH

// ---------------------------------------------------------------------
// Register byte offsets, port A space starts at zero.
// ---------------------------------------------------------------------
`define GP_OFS_PA_DIR 14'h0000
`define GP_OFS_PA_INEN 14'h0004
`define GP_OFS_PA_PU 14'h0008
`define GP_OFS_PA_PD 14'h000C
`define GP_OFS_PA_OD 14'h0010
`define GP_OFS_PA_DRV 14'h0014
`define GP_OFS_PA_LOCK 14'h0018
`define GP_OFS_PA_DIN 14'h001C
`define GP_OFS_PA_DOUT 14'h0020
`define GP_OFS_PA_SRR 14'h0024
`define GP_OFS_PA_RR 14'h0028
// Port B space sits one port window above port A.
`define GP_OFS_PB_DIR 14'h2000

// ---------------------------------------------------------------------
// Implemented bit masks and field constants.
// ---------------------------------------------------------------------
`define GP_PA_PIN_MASK 16'hF2FF
`define GP_PA_DRV_MASK 32'hFF0CFFFF
`define GP_PB_PIN_MASK 16'h719F
`define GP_LOCK_KEY 16'h5FA0

// ---------------------------------------------------------------------
// Reset values.
// ---------------------------------------------------------------------
`define GP_PA_INEN_RST 16'h0200
`define GP_PA_PU_RST 16'h3200
`define GP_PA_DIN_RST 16'h3200

// ---------------------------------------------------------------------
// Avalon response codes.
// ---------------------------------------------------------------------
`define GP_RESP_OKAY 2'h0
`define GP_RESP_SLVERR 2'h2

`endif

// ==== core/gpio_port_pin_control.sv ====
// Operation
// - pull-down bit enables that pin's pull-down.
// - pull-up wins, pull-down blocked when both.
// - open-drain bit selects open-drain over push-pull.
// - two-bit code picks 4/8/12/16 mA drive.
// - drive fields only at 31:24, 19:18, 15:0.
// - lock write needs key 0x5FA0, else dropped.
// - key field reads back the lock status.
// - locked pins ignore configuration changes.
// - lock accepted once, held until reset.
// - input register returns sensed pin levels.
// - output register holds driven output values.
// - set/clear register sets low, clears high.
// - set beats clear on the same pin.
// - clear register clears bits written one.
// - port B direction, implemented bits only.
// - pull-down register at 0x00C, resets zero.
// - input disabled pin reads zero; reset value 0x3200 reads pins 9, 12, 13 as one until the first enabled edge.
// - pull-up register resets to 0x3200.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`include "gpio_pin_regs.svh"

module gpio_port_pin_control import gpio_pin_pkg::*; #(
  parameter int ADDR_W = 14
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  output logic [1:0] response_o,
  input wire logic pa_port_rst_i,
  input wire logic pb_port_rst_i,
  input wire logic [15:0] pa_pad_in_i,
  output logic [15:0] pa_pad_out_o,
  output logic [15:0] pa_pad_oe_o,
  output logic [15:0] pa_pad_ien_o,
  output logic [15:0] pa_pad_pullup_o,
  output logic [15:0] pa_pad_pulldown_o,
  output logic [31:0] pa_pad_drive_o,
  output logic [15:0] pa_pin_lock_o,
  output logic pa_locked_o,
  output logic [15:0] pb_pad_oe_o
);

  // -------------------------------------------------------------------
  // Helper functions
  // -------------------------------------------------------------------

  // Byte-lane merge of a write into an old word.
  function automatic word_t wmerge(word_t old, word_t wd, word_t bem);
    wmerge = (old & ~bem) | (wd & bem);
  endfunction : wmerge

  // Keep locked bits at their old value and drop unimplemented bits.
  function automatic word_t lmerge(word_t old, word_t nw, word_t lk,
                                   word_t msk);
    lmerge = ((old & lk) | (nw & ~lk)) & msk;
  endfunction : lmerge

  // Widen a per-pin lock to cover both bits of each drive field.
  function automatic word_t lock2(logic [15:0] lk);
    word_t r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[2*i] = lk[i];
      r[2*i+1] = lk[i];
    end
    lock2 = r;
  endfunction : lock2

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  bus_state_t state_ff; // Bus sequencer.
  logic waitrequest_ff; // Drives waitrequest_o.
  word_t readdata_ff; // Captured read answer.
  logic [1:0] response_ff; // Captured bus response.
  logic [15:0] pa_dir_ff; // Port A direction.
  logic [15:0] pa_inen_ff; // Port A input enables.
  logic [15:0] pa_pu_ff; // Port A pull-up selects.
  logic [15:0] pa_pd_ff; // Port A pull-down selects.
  logic [15:0] pa_od_ff; // Port A open-drain selects.
  word_t pa_drv_ff; // Port A drive strength fields.
  logic [15:0] pa_lock_ff; // Port A per-pin lock bits.
  logic pa_locked_ff; // Port A lock accepted.
  logic [15:0] pa_din_ff; // Port A sensed input levels.
  logic [15:0] pa_out_ff; // Port A output values.
  logic [15:0] pb_dir_ff; // Port B direction.
  // Pad-facing copies, so every pad output leaves from a flop.
  logic [15:0] pad_out_ff;
  logic [15:0] pad_oe_ff;
  logic [15:0] pad_ien_ff;
  logic [15:0] pad_pu_ff;
  logic [15:0] pad_pd_ff;
  word_t pad_drv_ff;
  logic [15:0] pb_oe_ff;

  // -------------------------------------------------------------------
  // Bus decode
  // -------------------------------------------------------------------
  wire [13:0] addr = 14'(address_i);
  wire hit_dir = (addr == `GP_OFS_PA_DIR);
  wire hit_inen = (addr == `GP_OFS_PA_INEN);
  wire hit_pu = (addr == `GP_OFS_PA_PU);
  wire hit_pd = (addr == `GP_OFS_PA_PD);
  wire hit_od = (addr == `GP_OFS_PA_OD);
  wire hit_drv = (addr == `GP_OFS_PA_DRV);
  wire hit_lock = (addr == `GP_OFS_PA_LOCK);
  wire hit_din = (addr == `GP_OFS_PA_DIN);
  wire hit_dout = (addr == `GP_OFS_PA_DOUT);
  wire hit_srr = (addr == `GP_OFS_PA_SRR);
  wire hit_rr = (addr == `GP_OFS_PA_RR);
  wire hit_pbdir = (addr == `GP_OFS_PB_DIR);
  wire mapped = hit_dir | hit_inen | hit_pu | hit_pd | hit_od | hit_drv |
                hit_lock | hit_din | hit_dout | hit_srr | hit_rr |
                hit_pbdir;

  // A request is taken in idle; the write lands when the answer is seen.
  wire take = ce_i && (read_i || write_i) && (state_ff == BUS_IDLE);
  wire done = ce_i && (state_ff == BUS_ANSWER);
  wire wr_go = done && write_i;

  // Byte lanes not enabled are neither written nor used as command bits.
  wire [31:0] bem = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}},
                     {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};
  wire [31:0] wd = writedata_i & bem;
  wire [31:0] pa_msk = {16'h0000, `GP_PA_PIN_MASK};
  wire [31:0] lk32 = {16'h0000, pa_lock_ff};

  // -------------------------------------------------------------------
  // Next values for the configuration registers
  // -------------------------------------------------------------------
  // locked pins keep their configuration
  wire [31:0] nxt_dir = lmerge({16'h0000, pa_dir_ff},
    wmerge({16'h0000, pa_dir_ff}, writedata_i, bem), lk32, pa_msk);
  wire [31:0] nxt_inen = lmerge({16'h0000, pa_inen_ff},
    wmerge({16'h0000, pa_inen_ff}, writedata_i, bem), lk32, pa_msk);
  wire [31:0] nxt_pu = lmerge({16'h0000, pa_pu_ff},
    wmerge({16'h0000, pa_pu_ff}, writedata_i, bem), lk32, pa_msk);
  wire [31:0] nxt_pd = lmerge({16'h0000, pa_pd_ff},
    wmerge({16'h0000, pa_pd_ff}, writedata_i, bem), lk32, pa_msk);
  wire [31:0] nxt_od = lmerge({16'h0000, pa_od_ff},
    wmerge({16'h0000, pa_od_ff}, writedata_i, bem), lk32, pa_msk);
  wire [31:0] nxt_drv = lmerge(pa_drv_ff,
    wmerge(pa_drv_ff, writedata_i, bem), lock2(pa_lock_ff),
    `GP_PA_DRV_MASK);
  // port B direction, implemented bits only
  wire [31:0] nxt_pbdir = wmerge({16'h0000, pb_dir_ff}, writedata_i, bem) &
                          {16'h0000, `GP_PB_PIN_MASK};

  // -------------------------------------------------------------------
  // Output data and lock next values
  // -------------------------------------------------------------------
  // plain read/write of the output values
  wire [31:0] nxt_dout_wr = wmerge({16'h0000, pa_out_ff}, writedata_i, bem)
                            & pa_msk;
  wire [15:0] sr_set = wd[15:0] & `GP_PA_PIN_MASK;
  wire [15:0] sr_clr = wd[31:16] & `GP_PA_PIN_MASK;
  // set low half, clear high half
  // set applied last so it wins
  wire [15:0] nxt_dout_sr = (pa_out_ff & ~sr_clr) | sr_set;
  wire [15:0] nxt_dout_rr = pa_out_ff & ~(wd[15:0] & `GP_PA_PIN_MASK);
  // only the first accepted write counts
  wire lock_ok = wr_go && hit_lock && !pa_locked_ff &&
                 (wd[31:16] == `GP_LOCK_KEY) && (&byteenable_i[3:2]);

  // -------------------------------------------------------------------
  // Read mux
  // -------------------------------------------------------------------
  // unimplemented bits are never stored, so they read zero
  // write-only registers fall through to zero
  wire [31:0] rd_word =
    hit_dir ? {16'h0000, pa_dir_ff} :
    hit_inen ? {16'h0000, pa_inen_ff} :
    hit_pu ? {16'h0000, pa_pu_ff} :
    hit_pd ? {16'h0000, pa_pd_ff} :
    hit_od ? {16'h0000, pa_od_ff} :
    hit_drv ? pa_drv_ff :
    hit_lock ? {15'h0000, pa_locked_ff, pa_lock_ff} :
    hit_din ? {16'h0000, pa_din_ff} :
    hit_dout ? {16'h0000, pa_out_ff} :
    hit_pbdir ? {16'h0000, pb_dir_ff} : 32'h0000_0000;

  // -------------------------------------------------------------------
  // Bus sequencer
  // -------------------------------------------------------------------
  // Answer one cycle after the request; the answer is captured then so
  // read data stand steady while the master samples them.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= BUS_IDLE;
      waitrequest_ff <= 1'b1;
      readdata_ff <= 32'h0000_0000;
      response_ff <= `GP_RESP_OKAY;
    end else if (ce_i) begin
      case (state_ff)
        BUS_IDLE: begin
          if (take) begin
            state_ff <= BUS_ANSWER;
            waitrequest_ff <= 1'b0;
            readdata_ff <= read_i ? rd_word : 32'h0000_0000;
            response_ff <= mapped ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
          end
        end
        BUS_ANSWER: begin
          state_ff <= BUS_IDLE;
          waitrequest_ff <= 1'b1;
        end
        default: begin
          state_ff <= BUS_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Port A configuration registers
  // -------------------------------------------------------------------
  // Port reset restores the same values as the system reset.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pa_dir_ff <= 16'h0000;
      pa_inen_ff <= `GP_PA_INEN_RST;
      // pull-ups on pins 9, 12, 13
      pa_pu_ff <= `GP_PA_PU_RST;
      pa_pd_ff <= 16'h0000;
      pa_od_ff <= 16'h0000;
      pa_drv_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      if (pa_port_rst_i) begin
        pa_dir_ff <= 16'h0000;
        pa_inen_ff <= `GP_PA_INEN_RST;
        pa_pu_ff <= `GP_PA_PU_RST;
        pa_pd_ff <= 16'h0000;
        pa_od_ff <= 16'h0000;
        pa_drv_ff <= 32'h0000_0000;
      end else if (wr_go) begin
        if (hit_dir) pa_dir_ff <= nxt_dir[15:0];
        if (hit_inen) pa_inen_ff <= nxt_inen[15:0];
        if (hit_pu) pa_pu_ff <= nxt_pu[15:0];
        if (hit_pd) pa_pd_ff <= nxt_pd[15:0];
        if (hit_od) pa_od_ff <= nxt_od[15:0];
        if (hit_drv) pa_drv_ff <= nxt_drv;
      end
    end
  end

  // -------------------------------------------------------------------
  // Port A lock, output data and input sampling
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pa_lock_ff <= 16'h0000;
      pa_locked_ff <= 1'b0;
      pa_out_ff <= 16'h0000;
      pa_din_ff <= `GP_PA_DIN_RST;
    end else if (ce_i) begin
      pa_din_ff <= pa_pad_in_i & pa_inen_ff & `GP_PA_PIN_MASK;
      if (pa_port_rst_i) begin
        pa_lock_ff <= 16'h0000;
        pa_locked_ff <= 1'b0;
        pa_out_ff <= 16'h0000;
      end else begin
        if (lock_ok) begin
          pa_lock_ff <= wd[15:0] & `GP_PA_PIN_MASK;
          pa_locked_ff <= 1'b1;
        end
        if (wr_go && hit_dout) begin
          pa_out_ff <= nxt_dout_wr[15:0];
        end else if (wr_go && hit_srr) begin
          pa_out_ff <= nxt_dout_sr;
        end else if (wr_go && hit_rr) begin
          pa_out_ff <= nxt_dout_rr;
        end
      end
    end
  end

  // -------------------------------------------------------------------
  // Port B direction
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pb_dir_ff <= 16'h0000;
    end else if (ce_i) begin
      if (pb_port_rst_i) begin
        pb_dir_ff <= 16'h0000;
      end else if (wr_go && hit_pbdir) begin
        pb_dir_ff <= nxt_pbdir[15:0];
      end
    end
  end

  // -------------------------------------------------------------------
  // Pad control stage
  // -------------------------------------------------------------------
  // One flop of lag to the pads buys clean, glitch-free pad controls.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pad_out_ff <= 16'h0000;
      pad_oe_ff <= 16'h0000;
      pad_ien_ff <= 16'h0000;
      pad_pu_ff <= 16'h0000;
      pad_pd_ff <= 16'h0000;
      pad_drv_ff <= 32'h0000_0000;
      pb_oe_ff <= 16'h0000;
    end else if (ce_i) begin
      pad_oe_ff <= pa_dir_ff & ~(pa_od_ff & pa_out_ff);
      pad_out_ff <= pa_out_ff & ~pa_od_ff;
      pad_ien_ff <= pa_inen_ff;
      pad_pu_ff <= pa_pu_ff;
      pad_pd_ff <= pa_pd_ff & ~pa_pu_ff;
      // code 00..11 gives 4..16 mA at the pad
      pad_drv_ff <= pa_drv_ff;
      pb_oe_ff <= pb_dir_ff;
    end
  end

  assign readdata_o = readdata_ff;
  assign waitrequest_o = waitrequest_ff;
  assign response_o = response_ff;
  assign pa_pad_out_o = pad_out_ff;
  assign pa_pad_oe_o = pad_oe_ff;
  assign pa_pad_ien_o = pad_ien_ff;
  assign pa_pad_pullup_o = pad_pu_ff;
  assign pa_pad_pulldown_o = pad_pd_ff;
  assign pa_pad_drive_o = pad_drv_ff;
  assign pa_pin_lock_o = pa_lock_ff;
  assign pa_locked_o = pa_locked_ff;
  assign pb_pad_oe_o = pb_oe_ff;

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_lock_write;
    wr_go && hit_lock && !pa_port_rst_i;
  endsequence

  sequence s_bad_key;
    s_lock_write ##0 (wd[31:16] != `GP_LOCK_KEY);
  endsequence

  chk_pull_priority: assert property (
    (pa_pad_pulldown_o & pa_pad_pullup_o) == 16'h0000)
    else $error("pull-down active together with pull-up");

  // An open-drain pin asked to go high must be released, not driven.
  chk_od_no_high: assert property (
    ce_i && !pa_port_rst_i |=> (((pa_pad_oe_o | pa_pad_out_o) &
      $past(pa_od_ff & pa_out_ff)) == 16'h0000))
    else $error("open-drain pin drove a high");

  chk_key_reject: assert property (
    s_bad_key |=> $stable(pa_lock_ff) && $stable(pa_locked_ff))
    else $error("lock changed by a write with a wrong key");

  chk_key_status: assert property (
    take && read_i && hit_lock && !lock_ok |=>
      readdata_o[31:16] == {15'h0000, $past(pa_locked_ff)})
    else $error("key field did not return lock status");

  chk_lock_freeze: assert property (
    wr_go && hit_pd && !pa_port_rst_i |=>
      ((pa_pd_ff ^ $past(pa_pd_ff)) & $past(pa_lock_ff)) == 16'h0000)
    else $error("locked pull-down bit changed");

  chk_write_once: assert property (
    pa_locked_ff && !pa_port_rst_i |=> pa_locked_ff && $stable(pa_lock_ff))
    else $error("lock bits changed after lock");

  // The reset value of the input register is not gated, so the check
  // starts only with the first edge that samples the pins.
  chk_input_gate: assert property (
    ce_i && !rst_i |=> (pa_din_ff & ~$past(pa_inen_ff)) == 16'h0000)
    else $error("disabled input read as one");

  chk_set_wins: assert property (
    wr_go && hit_srr && !pa_port_rst_i |=>
      (pa_out_ff & $past(sr_set)) == $past(sr_set) &&
      (pa_out_ff & $past(sr_clr & ~sr_set)) == 16'h0000)
    else $error("set/clear register result wrong");

  chk_clear_only: assert property (
    wr_go && hit_rr && !pa_port_rst_i |=>
      pa_out_ff == ($past(pa_out_ff) &
        ~($past(wd[15:0]) & `GP_PA_PIN_MASK)))
    else $error("clear register touched other bits");

  chk_wo_read: assert property (
    take && read_i && (hit_srr || hit_rr) |=> readdata_o == 32'h0000_0000
      ##1 $stable(pa_out_ff))
    else $error("write-only register read nonzero or had effect");

endmodule : gpio_port_pin_control
